//--- flash_seq_pkg.sv
// Constants and types shared by the self-programming flash sequencer
package flash_seq_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   localparam logic [4:0]  CTRL_RESET    = 5'h00;

   // ****************************************
   // Commands in control bits [4:0]
   // ****************************************
   localparam logic [4:0] CMD_LOAD  = 5'h01;
   localparam logic [4:0] CMD_ERASE = 5'h03;
   localparam logic [4:0] CMD_WRITE = 5'h05;
   localparam int         CTRL_ENABLE_BIT = 0;

   // ****************************************
   // Flash geometry and timing
   // ****************************************
   localparam int          PAGE_COUNT  = 128;
   localparam int          PAGE_WORDS  = 64;
   localparam int          PC_W        = 13;
   localparam int          PAGE_MSB    = 13;
   localparam int          PAGE_LSB    = 7;
   localparam int          WORD_MSB    = 6;
   localparam int          WORD_LSB    = 1;
   localparam logic [2:0]  ISSUE_WINDOW_CYCLES = 3'h4;
   localparam logic [12:0] APP_RESET_ADDR = 13'h0000;
   localparam logic [12:0] BOOT_START_2P  = 13'h1f80;
   localparam logic [12:0] BOOT_START_4P  = 13'h1f00;
   localparam logic [12:0] BOOT_START_8P  = 13'h1e00;
   localparam logic [12:0] BOOT_START_16P = 13'h1c00;
   localparam int          OP_CYCLES_DEFAULT = 1024;

   typedef enum logic {
      OP_ERASE = 1'b0,
      OP_WRITE = 1'b1
   } op_mode_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARMED = 2'b01,
      ST_BUSY  = 2'b10
   } seq_state_e;
endpackage : flash_seq_pkg

//--- flash_op_if.sv
// Handshake between sequencer control and the erase/write engine
`timescale 1ns/1ps
interface flash_op_if;
   import flash_seq_pkg::*;
   logic       start;
   op_mode_e   mode;
   logic       busy;
   logic       done;
   logic       word_valid;
   logic [5:0] word_idx;

   modport seq    (output start, mode, input busy, done, word_valid, word_idx);
   modport engine (input start, mode, output busy, done, word_valid, word_idx);
endinterface : flash_op_if

//--- page_buffer.sv
// Temporary page buffer, random-order word load
`timescale 1ns/1ps
module page_buffer
   import flash_seq_pkg::*;
#(
   parameter int WORDS = PAGE_WORDS,
   parameter int WIDTH = 16
) (
   input  wire logic                     pclk,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(WORDS)-1:0] wr_idx,
   input  wire logic [WIDTH-1:0]         wr_data,
   input  wire logic [$clog2(WORDS)-1:0] rd_idx,
   output logic      [WIDTH-1:0]         rd_data
);
   logic [WIDTH-1:0] mem [WORDS];

   if (WORDS < 2 || WIDTH < 1) begin : g_bad
      $error("page_buffer: unsupported geometry");
   end

   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   always_ff @(posedge pclk) begin
      rd_data <= mem[rd_idx];
   end

   a_slot_written: assert property (@(posedge pclk) wr_en |=> mem[$past(wr_idx)] == $past(wr_data))
      else $error("buffer slot not loaded");
endmodule : page_buffer

//--- flash_op_engine.sv
// Erase/write engine: streams the page buffer on write only, then waits out the program time
`timescale 1ns/1ps
module flash_op_engine
   import flash_seq_pkg::*;
#(
   parameter int OP_CYCLES = OP_CYCLES_DEFAULT
) (
   input  wire logic pclk,
   input  wire logic presetn,
   flash_op_if.engine op
);
   logic        walking_reg;
   logic [31:0] cnt_reg;

   if (OP_CYCLES < 1) begin : g_bad
      $error("flash_op_engine: OP_CYCLES must be at least 1");
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op.busy       <= 1'b0;
         op.done       <= 1'b0;
         op.word_valid <= 1'b0;
         op.word_idx   <= 6'h00;
         walking_reg   <= 1'b0;
         cnt_reg       <= 32'h0;
      end else begin
         op.done <= 1'b0;
         if (op.start && !op.busy) begin
            op.busy       <= 1'b1;
            walking_reg   <= (op.mode == OP_WRITE);
            op.word_valid <= (op.mode == OP_WRITE);
            op.word_idx   <= 6'h00;
            cnt_reg       <= 32'(OP_CYCLES);
         end else if (walking_reg) begin
            // Whole page goes out, never a partial one
            if (op.word_idx == 6'(PAGE_WORDS - 1)) begin
               walking_reg   <= 1'b0;
               op.word_valid <= 1'b0;
            end else begin
               op.word_idx <= op.word_idx + 6'h01;
            end
         end else if (op.busy) begin
            if (cnt_reg == 32'h1) begin
               op.busy <= 1'b0;
               op.done <= 1'b1;
            end
            cnt_reg <= cnt_reg - 32'h1;
         end
      end
   end

   a_write_walk: assert property (@(posedge pclk) disable iff (!presetn)
         op.start && !op.busy && op.mode == OP_WRITE |=> op.word_valid && op.word_idx == 6'h00 ##63
         op.word_valid && op.word_idx == 6'h3f)
      else $error("page walk not 64 words");
   a_done_after: assert property (@(posedge pclk) disable iff (!presetn) op.done |-> $past(op.busy) && !op.busy)
      else $error("done without busy");
endmodule : flash_op_engine

//--- self_program_flash_sequencer.sv
// Self-programming flash sequencer with APB control and status registers
`timescale 1ns/1ps
module self_program_flash_sequencer
   import flash_seq_pkg::*;
#(
   parameter int OP_CYCLES = OP_CYCLES_DEFAULT
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  boot_size_select,
   input  wire logic        boot_reset_vector_select,
   input  wire logic        boot_section_write_lock,
   input  wire logic        app_section_write_lock,
   input  wire logic        store_op_valid,
   input  wire logic [12:0] store_op_pc,
   input  wire logic [15:0] store_op_addr,
   input  wire logic [15:0] store_op_data,
   output logic             cpu_halt,
   output logic [12:0]      reset_vector,
   output logic             flash_erase_req,
   output logic             flash_prog_we,
   output logic [12:0]      flash_prog_addr,
   output logic [15:0]      flash_prog_data
);
   // ****************************************
   // Declarations
   // ****************************************
   flash_op_if op ();

   seq_state_e  state_reg;
   logic [4:0]  self_program_control_reg;
   logic [2:0]  arm_cnt_reg;
   logic        fuse_valid_reg;
   logic [1:0]  boot_size_reg;
   logic        boot_rst_reg;
   logic        boot_lock_reg;
   logic        app_lock_reg;
   logic        blocked_reg;
   logic [6:0]  op_page_reg;
   logic        word_valid_d_reg;
   logic [5:0]  word_idx_d_reg;
   logic [15:0] buf_rd_data;
   logic [12:0] boot_start;
   logic [6:0]  tgt_page;
   logic        store_hit;
   logic        pc_in_boot;
   logic        tgt_in_boot;
   logic        tgt_locked;
   logic        acc_load;
   logic        acc_erase;
   logic        acc_write;
   logic        drop;
   logic        ctrl_wr;
   logic        setup;

   function automatic logic [12:0] boot_start_of(input logic [1:0] sz);
      logic [12:0] r;
      r = BOOT_START_16P;
      case (sz)
         2'b11:   r = BOOT_START_2P;
         2'b10:   r = BOOT_START_4P;
         2'b01:   r = BOOT_START_8P;
         default: r = BOOT_START_16P;
      endcase
      return r;
   endfunction : boot_start_of

   if (OP_CYCLES < 1) begin : g_bad
      $error("self_program_flash_sequencer: OP_CYCLES must be at least 1");
   end

   // ****************************************
   // Fuse capture after reset
   // ****************************************
   // Fuses are inputs only; no path from CPU or bus writes them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_valid_reg <= 1'b0;
         boot_size_reg  <= 2'b00;
         boot_rst_reg   <= 1'b1;
         boot_lock_reg  <= 1'b0;
         app_lock_reg   <= 1'b0;
         reset_vector   <= APP_RESET_ADDR;
      end else if (!fuse_valid_reg) begin
         fuse_valid_reg <= 1'b1;
         boot_size_reg  <= boot_size_select;
         boot_rst_reg   <= boot_reset_vector_select;
         boot_lock_reg  <= boot_section_write_lock;
         app_lock_reg   <= app_section_write_lock;
         reset_vector   <= boot_reset_vector_select ? APP_RESET_ADDR
                                                    : boot_start_of(boot_size_select);
      end
   end

   // ****************************************
   // Command decode
   // ****************************************
   assign boot_start  = boot_start_of(boot_size_reg);
   assign tgt_page    = store_op_addr[PAGE_MSB:PAGE_LSB];
   assign store_hit   = store_op_valid && state_reg == ST_ARMED;
   assign pc_in_boot  = store_op_pc >= boot_start;
   // Any target reachable from boot code; lock fuses gate erase and write, never load
   assign tgt_in_boot = {tgt_page, 6'h00} >= boot_start;
   // Programmed lock reads as zero
   assign tgt_locked  = tgt_in_boot ? !boot_lock_reg : !app_lock_reg;
   assign acc_load    = store_hit && pc_in_boot && self_program_control_reg == CMD_LOAD;
   assign acc_erase   = store_hit && pc_in_boot && !tgt_locked && self_program_control_reg == CMD_ERASE;
   assign acc_write   = store_hit && pc_in_boot && !tgt_locked && self_program_control_reg == CMD_WRITE;
   assign drop        = (store_hit && !acc_load && !acc_erase && !acc_write)
                     || (state_reg == ST_ARMED && !store_op_valid && arm_cnt_reg == 3'h1);
   assign setup       = psel && !penable;
   assign ctrl_wr     = psel && penable && pwrite && paddr == CTRL_OFFSET && state_reg != ST_BUSY;

   // ****************************************
   // Control register and sequencing
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg                <= ST_IDLE;
         self_program_control_reg <= CTRL_RESET;
         arm_cnt_reg              <= 3'h0;
      end else begin
         case (state_reg)
            ST_IDLE, ST_ARMED: begin
               if (acc_erase || acc_write) begin
                  state_reg <= ST_BUSY;
               end else if (acc_load || drop) begin
                  state_reg                <= ST_IDLE;
                  self_program_control_reg <= CTRL_RESET;
               end else if (ctrl_wr) begin
                  self_program_control_reg <= pwdata[4:0];
                  arm_cnt_reg              <= ISSUE_WINDOW_CYCLES;
                  state_reg                <= pwdata[CTRL_ENABLE_BIT] ? ST_ARMED : ST_IDLE;
               end else if (state_reg == ST_ARMED) begin
                  arm_cnt_reg <= arm_cnt_reg - 3'h1;
               end
            end
            ST_BUSY: begin
               if (op.done) begin
                  state_reg                <= ST_IDLE;
                  self_program_control_reg <= CTRL_RESET;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Drop indicator; a fresh drop wins over the clear on rearm
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blocked_reg <= 1'b0;
      end else if (drop) begin
         blocked_reg <= 1'b1;
      end else if (ctrl_wr) begin
         blocked_reg <= 1'b0;
      end
   end

   // ****************************************
   // Engine start and CPU stall
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op.start        <= 1'b0;
         op.mode         <= OP_ERASE;
         op_page_reg     <= 7'h00;
         cpu_halt        <= 1'b0;
         flash_erase_req <= 1'b0;
      end else begin
         op.start        <= acc_erase || acc_write;
         flash_erase_req <= acc_erase;
         if (acc_erase || acc_write) begin
            op.mode     <= acc_write ? OP_WRITE : OP_ERASE;
            op_page_reg <= tgt_page;
            cpu_halt    <= 1'b1;
         end else if (op.done) begin
            cpu_halt <= 1'b0;
         end
      end
   end

   page_buffer #(
      .WORDS (PAGE_WORDS),
      .WIDTH (16)
   ) u_buf (
      .pclk    (pclk),
      .wr_en   (acc_load),
      .wr_idx  (store_op_addr[WORD_MSB:WORD_LSB]),
      .wr_data (store_op_data),
      .rd_idx  (op.word_idx),
      .rd_data (buf_rd_data)
   );

   flash_op_engine #(
      .OP_CYCLES (OP_CYCLES)
   ) u_engine (
      .pclk    (pclk),
      .presetn (presetn),
      .op      (op)
   );

   // ****************************************
   // Flash array port
   // ****************************************
   // Buffer read is registered, so index and strobe lag one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_valid_d_reg <= 1'b0;
         word_idx_d_reg   <= 6'h00;
         flash_prog_we    <= 1'b0;
         flash_prog_addr  <= 13'h0000;
         flash_prog_data  <= 16'h0000;
      end else begin
         word_valid_d_reg <= op.word_valid;
         word_idx_d_reg   <= op.word_idx;
         flash_prog_we    <= word_valid_d_reg;
         if (acc_erase) begin
            flash_prog_addr <= {tgt_page, 6'h00};
         end else if (word_valid_d_reg) begin
            flash_prog_addr <= {op_page_reg, word_idx_d_reg};
            flash_prog_data <= buf_rd_data;
         end
      end
   end

   // ****************************************
   // APB slave
   // ****************************************
   // Zero wait states; reply prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (setup) begin
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            if (paddr == CTRL_OFFSET) begin
               prdata <= {27'h0, self_program_control_reg};
            end else if (paddr == STATUS_OFFSET) begin
               prdata <= {24'h0, fuse_valid_reg, blocked_reg, app_lock_reg, boot_lock_reg,
                          boot_rst_reg, boot_size_reg, cpu_halt};
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_window_expiry: assert property (@(posedge pclk) disable iff (!presetn)
         state_reg == ST_ARMED && arm_cnt_reg == 3'h1 && !store_op_valid
         |=> state_reg == ST_IDLE && self_program_control_reg == CTRL_RESET)
      else $error("armed command outlived window");
   a_window_open: assert property (@(posedge pclk) disable iff (!presetn)
         ctrl_wr && pwdata[CTRL_ENABLE_BIT] && !store_hit && !drop
         |=> (state_reg == ST_ARMED && !store_op_valid && !ctrl_wr) [*3] |=> state_reg == ST_ARMED)
      else $error("issue window shorter than four cycles");
   a_app_pc_ignored: assert property (@(posedge pclk) disable iff (!presetn)
         store_hit && !pc_in_boot |=> !op.start && !flash_erase_req && state_reg == ST_IDLE)
      else $error("store from application section acted");
   a_boot_lock: assert property (@(posedge pclk) disable iff (!presetn)
         store_hit && tgt_in_boot && !boot_lock_reg |=> !cpu_halt && !flash_erase_req)
      else $error("locked boot section programmed");
   a_app_lock: assert property (@(posedge pclk) disable iff (!presetn)
         store_hit && !tgt_in_boot && !app_lock_reg && self_program_control_reg != CMD_LOAD
         |=> state_reg == ST_IDLE && !cpu_halt)
      else $error("locked application section programmed");
   a_erase_page: assert property (@(posedge pclk) disable iff (!presetn)
         acc_erase |=> flash_erase_req && cpu_halt && flash_prog_addr == {$past(tgt_page), 6'h00})
      else $error("erase address wrong");
   a_halt_busy: assert property (@(posedge pclk) disable iff (!presetn)
         state_reg == ST_BUSY |-> cpu_halt && self_program_control_reg[CTRL_ENABLE_BIT])
      else $error("CPU not halted while programming");
   a_enable_clear: assert property (@(posedge pclk) disable iff (!presetn)
         op.done |=> !cpu_halt && !self_program_control_reg[CTRL_ENABLE_BIT] && state_reg == ST_IDLE)
      else $error("enable flag not cleared at completion");
   a_reset_vector: assert property (@(posedge pclk) disable iff (!presetn)
         fuse_valid_reg |-> reset_vector == (boot_rst_reg ? APP_RESET_ADDR : boot_start))
      else $error("reset vector wrong");
endmodule : self_program_flash_sequencer

//--- cpu_store_model.sv
// CPU core model that issues store-program-memory operations
`timescale 1ns/1ps
module cpu_store_model (
   input  wire logic        pclk,
   output logic             store_op_valid,
   output logic [12:0]      store_op_pc,
   output logic [15:0]      store_op_addr,
   output logic [15:0]      store_op_data
);
   // ****************************************
   // Store operation
   // ****************************************
   initial begin
      store_op_valid = 1'b0;
      store_op_pc = 13'h0000;
      store_op_addr = 16'h0000;
      store_op_data = 16'h0000;
   end

   // One-cycle pulse; qualifiers invert afterwards so stale values never look valid
   // No interrupt is taken between arming and issue
   task automatic issue(input logic [12:0] pc, input logic [15:0] addr, input logic [15:0] data);
      store_op_valid <= 1'b1;
      store_op_pc <= pc;
      store_op_addr <= addr;
      store_op_data <= data;
      @(posedge pclk);
      store_op_valid <= 1'b0;
      store_op_pc <= ~pc;
      store_op_addr <= ~addr;
      store_op_data <= ~data;
   endtask : issue
endmodule : cpu_store_model

//--- tb.sv
// Self-checking testbench for the self-programming flash sequencer
`timescale 1ns/1ps
module tb;
   import flash_seq_pkg::*;
   localparam int OPC = 8;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed, r;
   logic [1:0]  sz;
   logic        rst, blk, alk, valid, halt, ereq, we, e;
   logic [12:0] pc, rvec, faddr;
   logic [15:0] saddr, sdata, fdata;
   logic [15:0] mem [0:8191];
   logic [15:0] img [0:63];
   int          error_cnt, tests_run, act_cnt, halt_cyc;

   self_program_flash_sequencer #(.OP_CYCLES(OPC)) u_self_program_flash_sequencer (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .boot_size_select(sz), .boot_reset_vector_select(rst), .boot_section_write_lock(blk),
      .app_section_write_lock(alk), .store_op_valid(valid), .store_op_pc(pc),
      .store_op_addr(saddr), .store_op_data(sdata), .cpu_halt(halt), .reset_vector(rvec),
      .flash_erase_req(ereq), .flash_prog_we(we), .flash_prog_addr(faddr), .flash_prog_data(fdata));
   cpu_store_model u_cpu_store_model (.pclk(pclk), .store_op_valid(valid), .store_op_pc(pc),
      .store_op_addr(saddr), .store_op_data(sdata));

   // ****************************************
   // Clock, flash image and helpers
   // ****************************************
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (halt === 1'b1) halt_cyc++;
      if (ereq === 1'b1) begin
         act_cnt++;
         for (int w = 0; w < 64; w++) mem[{faddr[12:6], w[5:0]}] = 16'hffff;
      end
      if (we === 1'b1) begin
         act_cnt++;
         mem[faddr] = fdata;
         chk(32'(halt), 32'h1);
      end
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic logic [12:0] boot_start(input logic [1:0] s);
      case (s)
         2'h3: return BOOT_START_2P;
         2'h2: return BOOT_START_4P;
         2'h1: return BOOT_START_8P;
         default: return BOOT_START_16P;
      endcase
   endfunction : boot_start

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim();
      if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim

   // ****************************************
   // Bus and operation tasks
   // ****************************************
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic do_op(input logic [12:0] p, input logic [4:0] c, input logic [15:0] a, input int dly);
      apb(1'b1, CTRL_OFFSET, 32'(c));
      repeat (dly) @(posedge pclk);
      u_cpu_store_model.issue(p, a, 16'(rnd()));
      do apb(1'b0, CTRL_OFFSET, 32'h0); while (r[0] !== 1'b0);
   endtask : do_op

   task automatic refused(input logic [12:0] p, input logic [4:0] c, input logic [15:0] a, input int dly);
      int n;
      n = act_cnt;
      do_op(p, c, a, dly);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk(32'(r[6]), 32'h1);
      chk(32'(act_cnt), 32'(n));
   endtask : refused

   task automatic do_reset(input logic [3:0] f);
      presetn <= 1'b0;
      // Fuse level 0 means programmed: f[3] locks boot, f[2] picks the reset vector
      {blk, alk, rst} <= {~f[3], f[3] | ~f[2], f[2]};
      sz <= f[1:0];
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask : do_reset

   task automatic update(input logic [6:0] pg, input logic [12:0] p);
      int h, off;
      logic [5:0] idx;
      do_op(p, CMD_ERASE, {2'h0, pg, 7'(rnd())}, 0);
      off = rnd();
      for (int i = 0; i < 64; i++) begin
         idx = 6'(i * 37 + off);
         img[idx] = 16'(rnd());
         apb(1'b1, CTRL_OFFSET, 32'(CMD_LOAD));
         repeat (i % 4) @(posedge pclk);
         u_cpu_store_model.issue(p, {2'h0, pg, idx, 1'b0}, img[idx]);
         do apb(1'b0, CTRL_OFFSET, 32'h0); while (r[0] !== 1'b0);
      end
      refused(p, CMD_LOAD, {2'h0, pg, 7'h00}, 4);
      refused(p, 5'h07, {2'h0, pg, 7'h00}, 0);
      h = halt_cyc;
      do_op(p, CMD_WRITE, {2'h0, pg, 7'h00}, 0);
      chk(32'(halt_cyc - h >= 64 + OPC), 32'h1);
      chk(32'(halt), 32'h0);
      for (int i = 0; i < 64; i++) chk(32'(mem[{pg, i[5:0]}]), 32'(img[i]));
   endtask : update

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {sz, rst, blk, alk} = 5'h1f;
      {error_cnt, tests_run, act_cnt, halt_cyc} = '0;
      seed = 32'd32294;
      for (int i = 0; i < 8192; i++) mem[i] = 16'h0000;
      for (int k = 0; k < 8; k++) begin
         do_reset(4'(k));
         chk(32'(rvec), k[2] ? 32'h0 : 32'(boot_start(k[1:0])));
         apb(1'b0, STATUS_OFFSET, 32'h0);
         chk(r, {24'h0, 1'b1, 1'b0, alk, blk, rst, sz, 1'b0});
         apb(1'b1, STATUS_OFFSET, 32'h0);
         apb(1'b0, STATUS_OFFSET, 32'h0);
         chk(32'(r[5:1]), 32'({alk, blk, rst, sz}));
      end
      do_reset(4'h3);
      apb(1'b0, 12'h008, 32'h0);
      chk(32'(e), 32'h1);
      update(7'(rnd() % 126), BOOT_START_2P + 13'(rnd() % 128));
      update(7'h7f, BOOT_START_2P);
      refused(13'h1f7f, CMD_ERASE, 16'h0280, 0);
      do_reset(4'hb);
      refused(BOOT_START_2P, CMD_ERASE, 16'h3f80, 0);
      refused(BOOT_START_2P, CMD_WRITE, 16'h3f00, 0);
      do_op(BOOT_START_2P, CMD_ERASE, 16'h0180, 0);
      chk(32'(mem[13'h00c0]), 32'hffff);
      do_reset(4'h7);
      refused(BOOT_START_2P, CMD_ERASE, 16'h0100, 0);
      do_op(BOOT_START_2P, CMD_ERASE, 16'h3f00, 0);
      chk(32'(mem[13'h1f80]), 32'hffff);
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      end_sim();
   end
endmodule : tb
